// file: logic/i2c_reservation_map.svh
// Register offsets, reset values and timing counts of the start/reservation control.
// Assumes a 200 MHz system clock and a 32-bit Avalon-MM register bus.
// Function
// - Idle bus: start request drives start, waits
// - Start request: immediate start or reservation
// - Reserved: master after stop, early writes ignored
// - Reservation accepted between start and stop
// - Reservation off: busy start request rejected
// - Reservation off: clear flag shows outcome
// - Arbitration loss or release: bus not ours
// - Init start off: enable sets busy
// - Init start on: enable clears busy
// - Enable on low data: falling edge start
// - Reservation needs stop interrupt or polling
// - Stop interrupt only when stop enable set
// - Arbitration loss: flag set, lines released
`ifndef I2C_RESERVATION_MAP_SVH
`define I2C_RESERVATION_MAP_SVH

// Byte offsets on the register bus
`define REG_CONTROL 5'h00
`define REG_STATUS 5'h04
`define REG_FLAGS 5'h08
`define REG_CLKSEL 5'h0C
`define REG_CLKEXT 5'h10
`define REG_SHIFT 5'h14

// Reset values
`define CONTROL_RESET 8'h00
`define STATUS_RESET 8'h00
`define FLAGS_RESET 8'h00
`define CLKSEL_RESET 4'h0

// Timing: start/stop hold time on the lines
`define CLK_PERIOD_NS 5
`define START_HOLD_NS 4000
`define START_HOLD_CYC ((`START_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Decision delay per divider code, in system clocks
`define DECIDE_CLK_00 4'h6
`define DECIDE_CLK_01 4'h6
`define DECIDE_CLK_10 4'hC
`define DECIDE_CLK_11 4'h3

`endif

// file: logic/i2c_reservation_pkg.sv
// Types shared by the start/reservation control and its line monitor.
// Assumes the constants header supplies all numbers.
package i2c_reservation_pkg;

  // Sequencer states, Gray coded along the reservation path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DECIDE = 3'b001,
    ST_RESERVED = 3'b011,
    ST_START = 3'b010,
    ST_WAIT = 3'b110,
    ST_ACTIVE = 3'b111,
    ST_STOP_LOW = 3'b101,
    ST_STOP_SCL = 3'b100
  } ctl_state_t;

  // Bus control register layout
  typedef struct packed {
    logic enable;
    logic relBus;
    logic rsvd5;
    logic stopIe;
    logic [1:0] rsvd32;
    logic start;
    logic stop;
  } control_t;

  // Bus status register layout
  typedef struct packed {
    logic master;
    logic arbLost;
    logic [3:0] rsvd;
    logic startDet;
    logic stopDet;
  } status_t;

  // Bus flag register layout
  typedef struct packed {
    logic startClear;
    logic busy;
    logic [3:0] rsvd;
    logic initStart;
    logic rsvDisable;
  } flags_t;

  // Sampled serial line pair
  typedef struct packed {
    logic scl;
    logic sda;
  } lines_t;

endpackage : i2c_reservation_pkg

// file: logic/i2c_line_monitor.sv
// Serial line synchroniser with start and stop condition detection.
// Assumes the lines are asynchronous to clk and sampled at 200 MHz.
module i2c_line_monitor
  import i2c_reservation_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic enable,
  // Raw lines
  input wire logic sclIn,
  input wire logic sdaIn,
  // Events
  output logic startSeen,
  output logic stopSeen
);

  lines_t meta_r;
  lines_t sync_r;
  lines_t prev_r;

  // Two-stage synchroniser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 2'b11;
      sync_r <= 2'b11;
    end else begin
      meta_r <= '{scl: sclIn, sda: sdaIn};
      sync_r <= meta_r;
    end
  end

  // Previous sample, forced high while disabled so low data reads as a fall
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_r <= 2'b11;
    end else begin
      prev_r <= enable ? sync_r : 2'b11;
    end
  end

  // Edge decode on data while clock high
  assign startSeen = enable & prev_r.sda & ~sync_r.sda & sync_r.scl;
  assign stopSeen = enable & ~prev_r.sda & sync_r.sda & sync_r.scl;

endmodule : i2c_line_monitor

// file: logic/i2c_start_reservation_ctrl.sv
// Start-condition and communication-reservation control with Avalon-MM registers.
// Assumes a transfer engine on clk drives arbitration loss and extension-code flags,
// and takes over the lines once an address byte has been handed over.
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`include "i2c_reservation_map.svh"

module i2c_start_reservation_ctrl
  import i2c_reservation_pkg::*;
#(
  parameter int HOLD_CYC = `START_HOLD_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Serial clock line
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  // Serial data line
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Transfer engine
  input wire logic arbLost,
  input wire logic extCodeRx,
  output logic txStart,
  output logic [7:0] txByte,
  // Interrupt
  output logic serialIrq
);

  // Hold timer load, and the point where data is pulled during a stop
  localparam logic [11:0] HOLD_LOAD = 12'(HOLD_CYC - 1);
  localparam logic [11:0] HOLD_HALF = 12'(HOLD_CYC / 2);

  ctl_state_t state_r, state_nxt;
  control_t ctl_r, ctl_nxt;
  status_t st_r, st_nxt;
  flags_t fl_r, fl_nxt;
  logic [3:0] clkSel_r, clkSel_nxt;
  logic clkExt_r, clkExt_nxt;
  logic [11:0] cnt_r, cnt_nxt;
  logic enPrev_r;
  logic arbPrev_r;
  logic waitrequest_r;
  logic [31:0] readdata_r;
  logic sclOe_r, sclOe_nxt;
  logic sdaOe_r, sdaOe_nxt;
  logic txStart_r, txStart_nxt;
  logic [7:0] txByte_r, txByte_nxt;
  logic irq_r, irq_nxt;
  logic startSeen;
  logic stopSeen;

  // Line synchroniser and condition detector
  i2c_line_monitor u_i2c_line_monitor (
    .clk(clk),
    .reset_n(reset_n),
    .enable(ctl_r.enable),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );

  // Bus access decode; a write lands at the edge where waitrequest is low
  wire busWr = write & ~waitrequest_r & byteenable[0];
  wire rdTake = read & waitrequest_r;
  wire wrCtl = busWr & (address == `REG_CONTROL);
  wire wrFlags = busWr & (address == `REG_FLAGS);
  wire wrClkSel = busWr & (address == `REG_CLKSEL);
  wire wrClkExt = busWr & (address == `REG_CLKEXT);
  wire wrShift = busWr & (address == `REG_SHIFT);
  wire control_t wdCtl = control_t'(writedata[7:0]);

  // Read selection, unmapped offsets read zero
  wire [7:0] rdByte = (address == `REG_CONTROL) ? ctl_r :
                      (address == `REG_STATUS) ? st_r :
                      (address == `REG_FLAGS) ? fl_r :
                      (address == `REG_CLKSEL) ? {4'h0, clkSel_r} :
                      (address == `REG_CLKEXT) ? {7'h00, clkExt_r} : 8'h00;

  // Decision delay chosen by the divider bits
  wire [3:0] decideCyc = (clkSel_r[1:0] == 2'b00) ? `DECIDE_CLK_00 :
                         (clkSel_r[1:0] == 2'b01) ? `DECIDE_CLK_01 :
                         (clkSel_r[1:0] == 2'b10) ? `DECIDE_CLK_10 : `DECIDE_CLK_11;

  // Bus not ours: lost arbitration, or extension code dropped by release
  wire ownerless = arbLost | (extCodeRx & ctl_r.relBus);
  wire timerDone = (cnt_r == 12'h000);
  wire enableRise = ctl_r.enable & ~enPrev_r;
  // Loss interrupt once per event, even if the engine holds its flag
  wire arbRise = arbLost & ~arbPrev_r;

  // Next-state and register update logic
  always_comb begin
    state_nxt = state_r;
    ctl_nxt = ctl_r;
    st_nxt = st_r;
    fl_nxt = fl_r;
    clkSel_nxt = clkSel_r;
    clkExt_nxt = clkExt_r;
    cnt_nxt = timerDone ? 12'h000 : cnt_r - 12'h001;
    txStart_nxt = 1'b0;
    txByte_nxt = txByte_r;
    irq_nxt = 1'b0;
    // Busy state forced on enabling, whatever the lines show;
    // comes first, so a start seen in the same cycle still marks the bus busy
    if (enableRise) begin
      fl_nxt.busy = ~fl_r.initStart;
    end
    // Line events update busy and detection status
    if (startSeen) begin
      fl_nxt.busy = 1'b1;
      st_nxt.startDet = 1'b1;
      st_nxt.stopDet = 1'b0;
    end
    if (stopSeen) begin
      fl_nxt.busy = 1'b0;
      st_nxt.startDet = 1'b0;
      st_nxt.stopDet = 1'b1;
      st_nxt.master = 1'b0;
      irq_nxt = ctl_r.stopIe;
    end
    // Release bit acts once, then self-clears
    if (ctl_r.relBus) begin
      ctl_nxt.relBus = 1'b0;
    end
    case (state_r)
      ST_IDLE: begin
        if (ctl_r.stop) begin
          state_nxt = ST_STOP_LOW;
          cnt_nxt = HOLD_LOAD;
        end else if (ctl_r.start) begin
          state_nxt = ST_DECIDE;
          cnt_nxt = {8'h00, decideCyc - 4'h1};
        end
      end
      ST_DECIDE: begin
        // Bus state sampled once the divider delay has run out
        if (timerDone) begin
          ctl_nxt.start = 1'b0;
          if (!fl_r.busy) begin
            state_nxt = ST_START;
            cnt_nxt = HOLD_LOAD;
            st_nxt.master = 1'b1;
            fl_nxt.startClear = 1'b0;
          end else if (!fl_r.rsvDisable) begin
            state_nxt = ST_RESERVED;
          end else begin
            state_nxt = ST_IDLE;
            fl_nxt.startClear = 1'b1;
          end
        end
      end
      ST_RESERVED: begin
        // Shift writes here are dropped; only the wait state takes a byte
        if (stopSeen) begin
          state_nxt = ST_START;
          cnt_nxt = HOLD_LOAD;
          st_nxt.master = 1'b1;
        end
      end
      ST_START: begin
        if (timerDone) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Held in wait until software hands over the address byte
        if (ctl_r.stop) begin
          state_nxt = ST_STOP_LOW;
          cnt_nxt = HOLD_LOAD;
        end else if (wrShift) begin
          state_nxt = ST_ACTIVE;
          txStart_nxt = 1'b1;
          txByte_nxt = writedata[7:0];
        end
      end
      ST_ACTIVE: begin
        if (ctl_r.stop) begin
          state_nxt = ST_STOP_LOW;
          cnt_nxt = HOLD_LOAD;
        end
      end
      ST_STOP_LOW: begin
        if (timerDone) begin
          state_nxt = ST_STOP_SCL;
          cnt_nxt = HOLD_LOAD;
        end
      end
      ST_STOP_SCL: begin
        if (timerDone) begin
          state_nxt = ST_IDLE;
          ctl_nxt.stop = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Dropping out of the transfer releases both lines
    if (ownerless) begin
      state_nxt = ST_IDLE;
      st_nxt.master = 1'b0;
      ctl_nxt.start = 1'b0;
      if (arbLost) begin
        st_nxt.arbLost = 1'b1;
      end
    end
    // Loss interrupt on the first cycle of the flag only
    if (arbRise) begin
      irq_nxt = 1'b1;
    end
    // Disabled controller is held in its cleared state
    if (!ctl_r.enable) begin
      state_nxt = ST_IDLE;
      st_nxt = `STATUS_RESET;
      fl_nxt.busy = 1'b0;
      fl_nxt.startClear = 1'b0;
      ctl_nxt.start = 1'b0;
      ctl_nxt.stop = 1'b0;
      ctl_nxt.relBus = 1'b0;
      irq_nxt = 1'b0;
    end
    // Software writes; a request bit set by software wins over a clear
    if (wrCtl) begin
      ctl_nxt.enable = wdCtl.enable;
      ctl_nxt.stopIe = wdCtl.stopIe;
      ctl_nxt.relBus = ctl_nxt.relBus | (wdCtl.relBus & wdCtl.enable);
      ctl_nxt.start = ctl_nxt.start | (wdCtl.start & wdCtl.enable);
      ctl_nxt.stop = ctl_nxt.stop | (wdCtl.stop & wdCtl.enable);
      if (wdCtl.start & ~ctl_r.start) begin
        fl_nxt.startClear = 1'b0;
      end
    end
    if (wrFlags) begin
      fl_nxt.initStart = writedata[1];
      fl_nxt.rsvDisable = writedata[0];
    end
    // Transfer clock only changes while the controller is off
    if (wrClkSel & ~ctl_r.enable) begin
      clkSel_nxt = writedata[3:0];
    end
    if (wrClkExt & ~ctl_r.enable) begin
      clkExt_nxt = writedata[0];
    end
    // Line drivers follow the next state
    // Hand-over lets data go one cycle before clock, so the lines never show a stop
    sclOe_nxt = (state_nxt == ST_WAIT) | (state_nxt == ST_STOP_LOW) |
                ((state_r == ST_WAIT) & (state_nxt == ST_ACTIVE));
    sdaOe_nxt = (state_nxt == ST_START) | (state_nxt == ST_WAIT) | (state_nxt == ST_STOP_SCL) |
                ((state_nxt == ST_STOP_LOW) & (cnt_nxt < HOLD_HALF));
  end

  // Sequencer state and hold timer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 12'h000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Control and clock selection registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_r <= `CONTROL_RESET;
      clkSel_r <= `CLKSEL_RESET;
      clkExt_r <= 1'b0;
      enPrev_r <= 1'b0;
    end else begin
      ctl_r <= ctl_nxt;
      clkSel_r <= clkSel_nxt;
      clkExt_r <= clkExt_nxt;
      enPrev_r <= ctl_r.enable;
    end
  end

  // Status and flag registers, plus the loss flag of the last cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= `STATUS_RESET;
      fl_r <= `FLAGS_RESET;
      arbPrev_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      fl_r <= fl_nxt;
      arbPrev_r <= arbLost;
    end
  end

  // Registered line drivers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclOe_r <= 1'b0;
      sdaOe_r <= 1'b0;
    end else begin
      sclOe_r <= sclOe_nxt;
      sdaOe_r <= sdaOe_nxt;
    end
  end

  // Registered hand-over and interrupt outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txStart_r <= 1'b0;
      txByte_r <= 8'h00;
      irq_r <= 1'b0;
    end else begin
      txStart_r <= txStart_nxt;
      txByte_r <= txByte_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Bus handshake: one wait cycle, then a one-cycle answer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waitrequest_r <= 1'b1;
      readdata_r <= 32'h0000_0000;
    end else begin
      waitrequest_r <= ~((read | write) & waitrequest_r);
      if (rdTake) begin
        readdata_r <= {24'h00_0000, rdByte};
      end
    end
  end

  // Open-drain lines only ever pull low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = sclOe_r;
  assign sdaOe = sdaOe_r;
  assign txStart = txStart_r;
  assign txByte = txByte_r;
  assign serialIrq = irq_r;
  assign waitrequest = waitrequest_r;
  assign readdata = readdata_r;

endmodule : i2c_start_reservation_ctrl

// file: testbench/i2c_start_reservation_ctrl_properties.sv
// Port-level checks of the start/reservation control.
// Assumes one clock domain and a bind to every instance.
module i2c_start_reservation_ctrl_properties #(parameter int HOLD_CYC = 800) (
  // Watched ports
  input wire logic clk, reset_n, read, write, waitrequest, sclIn, sclOut, sclOe,
  input wire logic sdaIn, sdaOut, sdaOe, arbLost, extCodeRx, txStart, serialIrq,
  input wire logic [4:0] address,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata, readdata,
  input wire logic [7:0] txByte
);
  timeunit 1ns;
  timeprecision 100ps;
  int holdCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Cycles of data pulled while clock is free
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) holdCnt <= 0;
    else holdCnt <= (sdaOe && !sclOe) ? holdCnt + 1 : 0;
  end
  // Bus handshake and reset state
  a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no bus answer");
  a_bus_single: assert property (!waitrequest |=> waitrequest)
    else $error("answer too long");
  a_reset_quiet: assert property ($rose(reset_n) |-> waitrequest && !sclOe && !sdaOe && !txStart)
    else $error("outputs busy after reset");
  // Start condition and hand-over
  a_start_hold: assert property ($rose(sclOe) && sdaOe |-> holdCnt == HOLD_CYC)
    else $error("start hold length wrong");
  a_tx_wait: assert property (txStart |-> $past(sclOe) && $past(sdaOe))
    else $error("hand-over outside wait state");
  a_tx_free: assert property (txStart |-> ##[0:1] (!sclOe && !sdaOe))
    else $error("lines kept after hand-over");
  a_byte_cause: assert property ($changed(txByte) |-> ##[0:1] txStart)
    else $error("byte changed without hand-over");
  // Interrupt and ownership loss
  a_irq_pulse: assert property (serialIrq |=> !serialIrq)
    else $error("interrupt longer than a cycle");
  a_arb_free: assert property (arbLost |=> !sclOe && !sdaOe)
    else $error("lines held after loss");
  a_arb_irq: assert property ($rose(arbLost) |=> serialIrq)
    else $error("no interrupt on loss");
endmodule : i2c_start_reservation_ctrl_properties

bind i2c_start_reservation_ctrl i2c_start_reservation_ctrl_properties #(.HOLD_CYC(HOLD_CYC)) u_props (
  .clk, .reset_n, .read, .write, .waitrequest, .sclIn, .sclOut, .sclOe, .sdaIn, .sdaOut, .sdaOe,
  .arbLost, .extCodeRx, .txStart, .serialIrq, .address, .byteenable, .writedata, .readdata, .txByte
);

// file: testbench/i2c_bus_partner.sv
// Other master on the serial pair: start, link clock pulses, stop.
// Assumes pull-ups; its pulls are wired with the controller's enables.
module i2c_bus_partner (
  // Pacing clock
  input wire logic clk,
  // Line pulls, high holds the line low
  output logic sclPull,
  output logic sdaPull
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
  end
  // Half of the 80 ns link clock
  task automatic half();
    repeat (8) @(posedge clk);
  endtask : half
  // Data falls with clock high
  task automatic startCond();
    half();
    sdaPull <= 1'b1;
    half();
  endtask : startCond
  // Link clock runs inside a frame only
  task automatic pulses(input int n);
    repeat (n) begin
      sclPull <= 1'b1;
      half();
      sclPull <= 1'b0;
      half();
    end
  endtask : pulses
  // Data rises with clock high
  task automatic stopCond();
    sdaPull <= 1'b0;
    half();
  endtask : stopCond
endmodule : i2c_bus_partner

// file: testbench/tb_i2c_start_reservation_ctrl.sv
// Self-checking bench: register bus tasks, bus partner, corner cases.
// Assumes the bound checker and a shortened condition hold of 8 cycles.
module tb_i2c_start_reservation_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HOLD = 8;
  logic clk, reset_n, read, write, arbLost, extCodeRx, waitrequest;
  logic sclOut, sclOe, sdaOut, sdaOe, txStart, serialIrq, sclPull, sdaPull;
  logic [4:0] address;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, rdv;
  logic [7:0] txByte, lastTx, b;
  int err_count, n_compared, cyc, irqs, txCnt;
  int waitTbl[4] = '{46, 86, 172, 34};
  wire sclLine = !(sclOe || sclPull);
  wire sdaLine = !(sdaOe || sdaPull);

  i2c_start_reservation_ctrl #(.HOLD_CYC(HOLD)) u_i2c_start_reservation_ctrl (.clk, .reset_n, .address,
    .read, .write, .byteenable, .writedata, .readdata, .waitrequest, .sclIn(sclLine), .sclOut, .sclOe,
    .sdaIn(sdaLine), .sdaOut, .sdaOe, .arbLost, .extCodeRx, .txStart, .txByte, .serialIrq);
  i2c_bus_partner u_i2c_bus_partner (.clk, .sclPull, .sdaPull);

  task automatic results();
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One bus access, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h0, d};
    read <= !w;
    write <= w;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rdv = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask : acc
  task automatic rd(input logic [4:0] a, input logic [7:0] m, e);
    acc(1'b0, a, 8'h00);
    chk(rdv & 32'(m), 32'(e));
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Cycle limit, interrupt and hand-over tallies
  always @(posedge clk) begin
    cyc++;
    if (serialIrq === 1'b1) irqs++;
    if (txStart === 1'b1) begin
      txCnt++;
      lastTx = txByte;
    end
    if (cyc == 10000) begin
      err_count++;
      results();
    end
  end

  initial begin
    reset_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    byteenable = 4'hF;
    writedata = 32'h0;
    arbLost = 1'b0;
    extCodeRx = 1'b0;
    void'($urandom(66187));
    wt(2);
    reset_n <= 1'b1;
    wt(1);
    // Reset values and unmapped places
    acc(1'b1, 5'h18, 8'hFF);
    for (int a = 0; a < 32; a += 4) if (a != 20) rd(5'(a), 8'hFF, 8'h00);
    // Enable with init start off, then release by stop
    acc(1'b1, 5'h0C, 8'h01);
    acc(1'b1, 5'h00, 8'h80);
    rd(5'h08, 8'hFF, 8'h40);
    acc(1'b1, 5'h0C, 8'h03);
    rd(5'h0C, 8'hFF, 8'h01);
    acc(1'b1, 5'h00, 8'h81);
    wt(4 * HOLD + 10);
    rd(5'h08, 8'hFF, 8'h00);
    rd(5'h00, 8'hFF, 8'h80);
    // Immediate start for every divider code
    for (int k = 0; k < 4; k++) begin
      b = 8'($urandom);
      acc(1'b1, 5'h00, 8'h00);
      acc(1'b1, 5'h0C, 8'(k));
      acc(1'b1, 5'h08, 8'h02);
      acc(1'b1, 5'h00, 8'h80);
      rd(5'h08, 8'hFF, 8'h02);
      acc(1'b1, 5'h00, 8'h82);
      wt(waitTbl[k]);
      rd(5'h04, 8'hFF, 8'h82);
      rd(5'h08, 8'hFF, 8'h42);
      rd(5'h00, 8'hFF, 8'h80);
      while (sclOe !== 1'b1) @(posedge clk);
      acc(1'b1, 5'h14, b);
      wt(2);
      chk(32'(lastTx), 32'(b));
      acc(1'b1, 5'h00, 8'h81);
      wt(4 * HOLD + 10);
      rd(5'h04, 8'h81, 8'h01);
    end
    // Join a busy bus, reservation off
    acc(1'b1, 5'h00, 8'h00);
    acc(1'b1, 5'h08, 8'h03);
    u_i2c_bus_partner.startCond();
    acc(1'b1, 5'h00, 8'h80);
    wt(4);
    rd(5'h04, 8'h02, 8'h02);
    acc(1'b1, 5'h00, 8'hC0);
    acc(1'b1, 5'h00, 8'h82);
    wt(3 + 2);
    rd(5'h08, 8'hFF, 8'hC3);
    chk(32'(sdaOe), 32'h0);
    u_i2c_bus_partner.pulses(2);
    u_i2c_bus_partner.stopCond();
    chk(irqs, 0);
    // Reservation made between start and stop
    acc(1'b1, 5'h00, 8'h00);
    acc(1'b1, 5'h08, 8'h00);
    acc(1'b1, 5'h00, 8'h90);
    u_i2c_bus_partner.startCond();
    rd(5'h04, 8'h02, 8'h02);
    acc(1'b1, 5'h00, 8'h92);
    wt(waitTbl[3]);
    rd(5'h04, 8'h80, 8'h00);
    acc(1'b1, 5'h14, 8'h5A);
    wt(2);
    chk(txCnt, 4);
    u_i2c_bus_partner.pulses(3);
    u_i2c_bus_partner.stopCond();
    chk(irqs, 1);
    rd(5'h04, 8'h80, 8'h80);
    while (sclOe !== 1'b1) @(posedge clk);
    b = 8'($urandom);
    acc(1'b1, 5'h14, b);
    wt(2);
    chk(32'(lastTx), 32'(b));
    // Arbitration loss, then extension code with release
    arbLost <= 1'b1;
    wt(1);
    arbLost <= 1'b0;
    wt(2);
    rd(5'h04, 8'hC0, 8'h40);
    chk(irqs, 2);
    chk(32'({sclOut, sdaOut}), 32'h0);
    acc(1'b1, 5'h00, 8'h92);
    extCodeRx <= 1'b1;
    acc(1'b1, 5'h00, 8'hD0);
    extCodeRx <= 1'b0;
    u_i2c_bus_partner.startCond();
    u_i2c_bus_partner.stopCond();
    wt(3 * HOLD);
    rd(5'h04, 8'h80, 8'h00);
    results();
  end
endmodule : tb_i2c_start_reservation_ctrl
